//--- rtl/crc8_calc.sv
// Combinational checksum over a 16-bit command payload, MSB first.
// Assumes the caller registers the result where timing needs it.
`timescale 1ns/1ns
module crc8_calc
    import spi_port_pkg::*;
(
    input  wire logic [15:0] payload,
    output logic      [7:0]  crc
);

    always_comb begin
        logic [7:0] c;
        logic       fb;
        c  = CRC_SEED;
        fb = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ payload[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        crc = c;
    end

endmodule

//--- rtl/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes nothing reads the first stage except the second.
`timescale 1ns/1ns
module pin_sync
    import spi_port_pkg::*;
#(
    parameter int unsigned     W         = 3,
    parameter logic [W-1:0]    RESET_VAL = '0
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_r <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

//--- rtl/spi_addr_port.sv
// Serial slave port in addressed register mode, with error detection.
// Assumes the serial pins are asynchronous to clock and the serial clock is
// slower than a third of clock, so every edge is seen after resynchronising.
//
// Behaviour
// - Accept SPI mode 0 or mode 3 framing, serial clock up to 50 MHz.
// - After reset the port works in addressed register access mode only.
// - A frame runs chip select low to high; 16 clocks without checksum.
// - With checksum enabled a frame is 24 bits: command plus checksum byte.
// - Sample input on rising serial clock, change output on falling clock.
// - First bit 0 means write, 1 means read.
// - Then seven address bits, then eight data bits.
// - On reads the last eight input bits are ignored.
// - Address is latched and decoded at the eighth rising edge.
// - Reads drive register data from the eighth to fifteenth falling edge.
// - Writes without checksum take effect at the sixteenth rising edge.
// - Every frame first shifts out alignment byte 0x25.
// - Three checks: clock count, bad address, checksum; each enable and flag.
// - Checksum: polynomial x^8+x^2+x+1, seed zero, over 16 payload bits.
// - Wrong clock count sets its flag; short frames skip write, long still write.
// - Bad address or read-only write flagged at ninth edge; write suppressed.
// - Frame 0x6CA9 with valid checksum clears all flags at final edge.
`timescale 1ns/1ns
module spi_addr_port
    import spi_port_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       csN,
    input  wire logic       sclk,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdoOe,
    output logic      [7:0] switchData,
    output logic      [7:0] errCfg,
    output logic      [7:0] errFlags
);

    state_t      st_r;
    state_t      st_nxt;
    pins_t       pinRaw;
    pins_t       pinS;
    logic [23:0] rxShifted;
    logic [15:0] crcPayload;
    logic [7:0]  crcOut;

    // Nonexistent address other than a write to the clear address 0x6C, or a write to the read-only flag register
    function automatic logic addrInvalid(input logic rw, input logic [6:0] addr);
        logic known;
        known = (addr == ADDR_SWITCH) || (addr == ADDR_ERR_CFG) || (addr == ADDR_ERR_FLAGS);
        if (!rw && addr == CLEAR_FRAME[14:8]) begin
            return 1'b0;
        end
        return !known || (!rw && addr == ADDR_ERR_FLAGS);
    endfunction

    function automatic logic [7:0] regRead(input state_t s, input logic [6:0] addr);
        unique case (addr)
            ADDR_SWITCH:    return s.switchData;
            ADDR_ERR_CFG:   return s.errCfg;
            ADDR_ERR_FLAGS: return s.errFlags;
            default:        return 8'h00;
        endcase
    endfunction

    assign pinRaw = '{csN: csN, sclk: sclk, sdi: sdi};

    pin_sync #(
        .W         (3),
        .RESET_VAL (PINS_IDLE)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     (pinRaw),
        .q     (pinS)
    );

    assign rxShifted  = {st_r.rx[22:0], pinS.sdi};
    // Reads checksum what is sent back; writes check what came in
    assign crcPayload = st_r.rw ? {1'b1, st_r.addr, st_r.rdData} : rxShifted[23:8];

    crc8_calc u_crc (
        .payload (crcPayload),
        .crc     (crcOut)
    );

    always_comb begin
        logic       csFall;
        logic       csRise;
        logic       sclkRise;
        logic       sclkFall;
        logic [4:0] cntNew;
        logic [4:0] expected;
        logic [7:0] setF;
        logic [7:0] clrF;
        logic [7:0] wrData;
        logic [15:0] payload;
        logic       crcOk;

        st_nxt   = st_r;
        csFall   = st_r.csPrev && !pinS.csN;
        csRise   = !st_r.csPrev && pinS.csN;
        sclkRise = !pinS.csN && !st_r.sclkPrev && pinS.sclk;
        sclkFall = !pinS.csN && st_r.sclkPrev && !pinS.sclk;
        cntNew   = (st_r.cnt == CNT_MAX) ? CNT_MAX : st_r.cnt + CNT_ONE;
        expected = st_r.crcOn ? BITS_CRC : BITS_PLAIN;
        setF     = 8'h00;
        clrF     = 8'h00;
        wrData   = st_r.crcOn ? rxShifted[15:8] : rxShifted[7:0];
        payload  = st_r.crcOn ? rxShifted[23:8] : rxShifted[15:0];
        crcOk    = !st_r.crcOn || (crcOut == rxShifted[7:0]);

        st_nxt.csPrev   = pinS.csN;
        st_nxt.sclkPrev = pinS.sclk;

        if (csFall) begin
            // New frame: any earlier partial command is gone
            st_nxt.phase   = PH_FRAME;
            st_nxt.cnt     = CNT_ZERO;
            st_nxt.rx      = '0;
            st_nxt.rw      = 1'b0;
            st_nxt.addrBad = 1'b0;
            st_nxt.crcOn   = st_r.errCfg[ERR_CRC];
            st_nxt.tx      = ALIGN_PATTERN;
            st_nxt.sdo     = ALIGN_PATTERN[7];
            st_nxt.sdoOe   = 1'b1;
        end else begin
            unique case (st_r.phase)
                PH_IDLE: begin
                    st_nxt.sdoOe = 1'b0;
                end
                PH_FRAME: begin
                    if (csRise) begin
                        st_nxt.phase = PH_IDLE;
                        st_nxt.sdoOe = 1'b0;
                        if (st_r.cnt != expected && st_r.errCfg[ERR_SCLK]) begin
                            setF[ERR_SCLK] = 1'b1;
                        end
                    end else begin
                        if (sclkRise) begin
                            st_nxt.cnt = cntNew;
                            st_nxt.rx  = rxShifted;
                            if (cntNew == EDGE_ADDR) begin
                                st_nxt.rw     = rxShifted[7];
                                st_nxt.addr   = rxShifted[6:0];
                                st_nxt.rdData = regRead(st_r, rxShifted[6:0]);
                            end
                            if (cntNew == EDGE_CHECK && addrInvalid(st_r.rw, st_r.addr)) begin
                                st_nxt.addrBad = 1'b1;
                                if (st_r.errCfg[ERR_ADDR]) begin
                                    setF[ERR_ADDR] = 1'b1;
                                end
                            end
                            // Reads ignore the data and checksum bits
                            if (cntNew == expected && !st_r.rw) begin
                                if (!crcOk && st_r.errCfg[ERR_CRC]) begin
                                    setF[ERR_CRC] = 1'b1;
                                end
                                if (crcOk) begin
                                    if (payload == CLEAR_FRAME) begin
                                        clrF = 8'hFF;
                                    end else if (!st_r.addrBad) begin
                                        unique case (st_r.addr)
                                            ADDR_SWITCH: begin
                                                st_nxt.switchData = wrData;
                                            end
                                            ADDR_ERR_CFG: begin
                                                st_nxt.errCfg = wrData & CFG_MASK;
                                            end
                                            default: begin
                                            end
                                        endcase
                                    end
                                end
                            end
                        end
                        // Mode 3 opens with a falling edge before any bit: skip it
                        if (sclkFall && st_r.cnt != CNT_ZERO) begin
                            if (st_r.cnt == EDGE_ADDR) begin
                                st_nxt.tx  = st_r.rw ? st_r.rdData : 8'h00;
                                st_nxt.sdo = st_r.rw ? st_r.rdData[7] : 1'b0;
                            end else if (st_r.cnt == BITS_PLAIN && st_r.crcOn && st_r.rw) begin
                                st_nxt.tx  = crcOut;
                                st_nxt.sdo = crcOut[7];
                            end else begin
                                st_nxt.tx  = {st_r.tx[6:0], 1'b0};
                                st_nxt.sdo = st_r.tx[6];
                            end
                        end
                    end
                end
            endcase
        end

        // A flag raised in the same cycle as a clear survives
        st_nxt.errFlags = (st_r.errFlags & ~clrF) | setF;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r.phase      <= PH_IDLE;
            st_r.csPrev     <= 1'b1;
            st_r.sclkPrev   <= 1'b0;
            st_r.cnt        <= CNT_ZERO;
            st_r.crcOn      <= 1'b0;
            st_r.rx         <= '0;
            st_r.rw         <= 1'b0;
            st_r.addr       <= '0;
            st_r.addrBad    <= 1'b0;
            st_r.rdData     <= 8'h00;
            st_r.tx         <= 8'h00;
            st_r.sdo        <= 1'b0;
            st_r.sdoOe      <= 1'b0;
            st_r.switchData <= SWITCH_RESET;
            st_r.errCfg     <= CFG_RESET;
            st_r.errFlags   <= FLAGS_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sdo        = st_r.sdo;
    assign sdoOe      = st_r.sdoOe;
    assign switchData = st_r.switchData;
    assign errCfg     = st_r.errCfg;
    assign errFlags   = st_r.errFlags;

endmodule

//--- rtl/spi_port_pkg.sv
// Shared constants, types and state layout of the serial register port.
// Assumes one system clock; the serial pins arrive asynchronously and are resynchronised.
package spi_port_pkg;

    // Internal register addresses reached over the serial command
    localparam logic [6:0] ADDR_SWITCH    = 7'h01;
    localparam logic [6:0] ADDR_ERR_CFG   = 7'h02;
    localparam logic [6:0] ADDR_ERR_FLAGS = 7'h03;

    // Reset values and writable masks
    localparam logic [7:0] SWITCH_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET    = 8'h06;
    localparam logic [7:0] CFG_MASK     = 8'h07;
    localparam logic [7:0] FLAGS_RESET  = 8'h00;

    // Bit positions shared by the configuration and flag registers
    localparam int unsigned ERR_CRC  = 0;
    localparam int unsigned ERR_SCLK = 1;
    localparam int unsigned ERR_ADDR = 2;

    // Frame constants
    localparam logic [7:0]  ALIGN_PATTERN = 8'h25;
    localparam logic [15:0] CLEAR_FRAME   = 16'h6CA9;
    localparam logic [7:0]  CRC_POLY      = 8'h07;
    localparam logic [7:0]  CRC_SEED      = 8'h00;

    // Rising-edge counts within a frame
    localparam logic [4:0] EDGE_ADDR   = 5'h08;
    localparam logic [4:0] EDGE_CHECK  = 5'h09;
    localparam logic [4:0] BITS_PLAIN  = 5'h10;
    localparam logic [4:0] BITS_CRC    = 5'h18;
    localparam logic [4:0] CNT_MAX     = 5'h1F;
    localparam logic [4:0] CNT_ZERO    = 5'h00;
    localparam logic [4:0] CNT_ONE     = 5'h01;

    // Synchroniser reset value for {csN, sclk, sdi}: deselected, clock low
    localparam logic [2:0] PINS_IDLE = 3'h4;

    typedef enum logic {
        PH_IDLE  = 1'b0,
        PH_FRAME = 1'b1
    } phase_t;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic sdi;
    } pins_t;

    typedef struct packed {
        phase_t      phase;
        logic        csPrev;
        logic        sclkPrev;
        logic [4:0]  cnt;
        logic        crcOn;
        logic [23:0] rx;
        logic        rw;
        logic [6:0]  addr;
        logic        addrBad;
        logic [7:0]  rdData;
        logic [7:0]  tx;
        logic        sdo;
        logic        sdoOe;
        logic [7:0]  switchData;
        logic [7:0]  errCfg;
        logic [7:0]  errFlags;
    } state_t;

endpackage

//--- verif/spi_host_model.sv
// Host-side serial master that frames commands and captures the reply bits.
// Assumes the bench calls frame() from one process; 10 clocks per sclk half period.
`timescale 1ns/1ns
module spi_host_model (
    input  wire logic clock,
    input  wire logic sdo,
    input  wire logic sdoOe,
    output logic      csN,
    output logic      sclk,
    output logic      sdi
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    task automatic half();
        repeat (10) @(posedge clock);
        #1;
    endtask

    // Sends n bits from din[23] down; reply bit sampled at each rising edge
    task automatic frame(input logic [23:0] din, input int n, input logic m3,
                         output logic [23:0] dout);
        dout = '0;
        sclk = m3;
        half();
        csN = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            sdi = din[23-i];
            half();
            sclk = 1'b1;
            // A released line floats to its pull-up, so a dropped enable shows as ones
            dout[23-i] = sdoOe ? sdo : 1'b1;
            half();
        end
        sclk = m3;
        half();
        csN = 1'b1;
        // Released line must not keep showing the last bit
        sdi = ~sdi;
        half();
    endtask
endmodule

//--- verif/spi_port_sva.sv
// Port checker for the serial register port.
// Assumes one clock domain and the asynchronous active-low reset nrst.
`timescale 1ns/1ns
module spi_port_sva
    import spi_port_pkg::*;
(
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       csN,
    input wire logic       sclk,
    input wire logic       sdi,
    input wire logic       sdo,
    input wire logic       sdoOe,
    input wire logic [7:0] switchData,
    input wire logic [7:0] errCfg,
    input wire logic [7:0] errFlags
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_oe_after_select: assert property ($fell(csN) |-> ##[1:6] sdoOe)
        else $error("sdoOe not raised after select");
    a_oe_after_deselect: assert property ($rose(csN) |-> ##[1:6] !sdoOe)
        else $error("sdoOe not dropped after deselect");
    a_oe_rise_align: assert property ($rose(sdoOe) |-> !csN && !sdo)
        else $error("first reply bit wrong or not selected");
    a_oe_fall_deselected: assert property ($fell(sdoOe) |-> csN)
        else $error("sdoOe dropped while selected");
    a_sdo_hold_rise: assert property ($rose(sclk) && !csN |=> $stable(sdo)[*5])
        else $error("sdo changed after rising sclk");
    a_switch_on_rise: assert property ($changed(switchData) |-> sclk && !csN)
        else $error("switch register written outside a rising phase");
    a_cfg_on_rise: assert property ($changed(errCfg) |-> sclk && !csN)
        else $error("config register written outside a rising phase");
    a_reserved_zero: assert property (errCfg[7:3] == 5'h00 && errFlags[7:3] == 5'h00)
        else $error("reserved register bits not zero");

    cover property ($fell(csN));
    cover property ($changed(switchData));
    cover property ($rose(errFlags[ERR_ADDR]));
endmodule

bind spi_addr_port spi_port_sva u_sva (
    .clock(clock), .nrst(nrst), .csN(csN), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdoOe(sdoOe), .switchData(switchData),
    .errCfg(errCfg), .errFlags(errFlags)
);

//--- verif/testbench.sv
// Self-checking bench: register writes, reads and error cases over the serial port.
// Assumes the host model paces frames; results are settled when frame() returns.
`timescale 1ns/1ns
module testbench;
    import spi_port_pkg::*;

    logic        clock;
    logic        nrst;
    wire         csN, sclk, sdi, sdo, sdoOe;
    wire [7:0]   switchData, errCfg, errFlags;
    int          error_cnt;
    int          checked;
    logic [23:0] r;

    initial clock = 1'b0;
    always #4 clock = ~clock;

    spi_host_model u_host (.clock(clock), .sdo(sdo), .sdoOe(sdoOe),
        .csN(csN), .sclk(sclk), .sdi(sdi));
    spi_addr_port u_dut (.clock(clock), .nrst(nrst), .csN(csN), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .switchData(switchData),
        .errCfg(errCfg), .errFlags(errFlags));

    function automatic logic [7:0] crc8(input logic [15:0] p);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ (((c[7] ^ p[i]) == 1'b1) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The checksum byte is always appended; only a 24-bit frame sends it
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
                        input int n, input logic m3, input logic [7:0] bad);
        u_host.frame({rw, a, d, crc8({rw, a, d}) ^ bad}, n, m3, r);
    endtask

    task automatic clr(input int n);
        xfer(1'b0, 7'h6C, 8'hA9, n, 1'b0, 8'h00);
        chk("flags", 8'h00, errFlags);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        finish_test();
    end

    initial begin
        nrst = 1'b0;
        repeat (20) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (5) @(posedge clock);
        chk("switch", 8'h00, switchData);
        chk("cfg", CFG_RESET, errCfg);
        chk("flags", 8'h00, errFlags);
        xfer(1'b0, ADDR_SWITCH, 8'hA5, 16, 1'b0, 8'h00);
        chk("align", 8'h25, r[23:16]);
        chk("switch", 8'hA5, switchData);
        xfer(1'b1, ADDR_SWITCH, 8'h5A, 16, 1'b1, 8'h00);
        chk("rdata", 8'hA5, r[15:8]);
        chk("switch", 8'hA5, switchData);
        chk("oe", 8'h00, {7'h00, sdoOe});
        xfer(1'b1, ADDR_ERR_CFG, 8'h00, 16, 1'b0, 8'h00);
        chk("rdata", CFG_RESET, r[15:8]);
        $display("test basic access done");
        xfer(1'b0, ADDR_ERR_FLAGS, 8'hFF, 16, 1'b0, 8'h00);
        chk("flags", 8'h04, errFlags);
        xfer(1'b1, ADDR_ERR_FLAGS, 8'h00, 16, 1'b0, 8'h00);
        chk("rdata", 8'h04, r[15:8]);
        clr(16);
        xfer(1'b1, 7'h05, 8'h00, 16, 1'b0, 8'h00);
        chk("rdata", 8'h00, r[15:8]);
        chk("flags", 8'h04, errFlags);
        clr(16);
        xfer(1'b0, ADDR_SWITCH, 8'h33, 8, 1'b0, 8'h00);
        chk("switch", 8'hA5, switchData);
        chk("flags", 8'h02, errFlags);
        clr(16);
        xfer(1'b0, ADDR_SWITCH, 8'h3C, 17, 1'b1, 8'h00);
        chk("switch", 8'h3C, switchData);
        chk("flags", 8'h02, errFlags);
        clr(16);
        $display("test error flags done");
        xfer(1'b0, ADDR_ERR_CFG, 8'h07, 16, 1'b0, 8'h00);
        chk("cfg", 8'h07, errCfg);
        xfer(1'b0, ADDR_SWITCH, 8'hC3, 24, 1'b0, 8'h00);
        chk("switch", 8'hC3, switchData);
        xfer(1'b0, ADDR_SWITCH, 8'h11, 24, 1'b1, 8'h01);
        chk("switch", 8'hC3, switchData);
        chk("flags", 8'h01, errFlags);
        xfer(1'b1, ADDR_SWITCH, 8'h00, 24, 1'b0, 8'h00);
        chk("rdata", 8'hC3, r[15:8]);
        chk("rcrc", crc8({1'b1, ADDR_SWITCH, 8'hC3}), r[7:0]);
        clr(24);
        xfer(1'b0, ADDR_SWITCH, 8'h77, 16, 1'b0, 8'h00);
        chk("switch", 8'hC3, switchData);
        chk("flags", 8'h02, errFlags);
        xfer(1'b0, ADDR_ERR_CFG, 8'h00, 24, 1'b0, 8'h00);
        chk("cfg", 8'h00, errCfg);
        clr(16);
        xfer(1'b0, ADDR_ERR_FLAGS, 8'hFF, 16, 1'b0, 8'h00);
        chk("flags", 8'h00, errFlags);
        xfer(1'b0, ADDR_SWITCH, 8'h55, 8, 1'b0, 8'h00);
        chk("flags", 8'h00, errFlags);
        $display("test checksum done");
        finish_test();
    end
endmodule
